// ==== inc/accumulator_transfer_decode_defs.svh ====
// Purpose: Constants for the accumulator transfer decoder.
// Assumes: 10-bit instruction words and a 4-bit accumulator.
// Notes:   Offsets are byte addresses on the AXI4-Lite register port.
`ifndef ACCUMULATOR_TRANSFER_DECODE_DEFS_SVH
`define ACCUMULATOR_TRANSFER_DECODE_DEFS_SVH

// Opcodes of the transfer group.
`define OP_LOAD_PULLUP_CTRL_PORT2     10'h22F
`define OP_LOAD_PULLUP_CTRL_PORT3     10'h208
`define OP_LOAD_TIMER_ONE_RELOAD      10'h23F
`define OP_LOAD_CLOCK_CTRL            10'h209
`define OP_LOAD_INTERRUPT_CTRL_FIRST  10'h03D
`define OP_LOAD_INTERRUPT_CTRL_SECOND 10'h03E
`define OP_LOAD_TIMER_CTRL_FIRST      10'h20E
`define OP_LOAD_TIMER_CTRL_SECOND     10'h20F

// Register offsets.
`define REG_CTRL_OFFSET   4'h0
`define REG_SHADOW_OFFSET 4'h4
`define REG_RELOAD_OFFSET 4'h8

// Field positions and reset values.
`define CTRL_DECODE_EN_BIT 0
`define CTRL_RESET_VALUE   32'h0000_0001

// AXI response codes.
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== inc/accumulator_transfer_decode_pkg.sv ====
// Purpose: Types for the accumulator transfer decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   The peripheral control bank travels as one packed struct.
package accumulator_transfer_decode_pkg;

  // Peripheral control registers written by the transfer group.
  typedef struct packed {
    logic [3:0] pullup_ctrl_port_two;
    logic [3:0] pullup_ctrl_port_three;
    logic [7:0] timer_one_reload_value;
    logic [2:0] clock_source_control;
    logic [3:0] interrupt_ctrl_first;
    logic [3:0] interrupt_ctrl_second;
    logic [3:0] timer_ctrl_first;
    logic [3:0] timer_ctrl_second;
  } periph_ctrl_t;

  // Execution side effects that the core must honour.
  typedef struct packed {
    logic hit;
    logic skip_next;
    logic carry_write;
  } exec_effect_t;

endpackage

// ==== rtl/accumulator_transfer_decode.sv ====
// Purpose: Decodes the accumulator-to-control-register transfer group.
// Assumes: One instruction word offered per cycle with instr_valid.
// Notes:   Registers update at the end of the executing cycle.
//          The register port only switches the decoder on and off and
//          mirrors the control bank for software.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`include "accumulator_transfer_decode_defs.svh"

module accumulator_transfer_decode (
  // Clock and reset.
  input  wire logic                                       clk_sys,
  input  wire logic                                       rst,
  // Instruction and operands from the core.
  input  wire logic                                       instr_valid,
  input  wire logic [9:0]                                 instr_word,
  input  wire logic [3:0]                                 acc,
  input  wire logic [3:0]                                 reg_b,
  // Results towards the core and the peripherals.
  output accumulator_transfer_decode_pkg::exec_effect_t   effect,
  output accumulator_transfer_decode_pkg::periph_ctrl_t   periph,
  // AXI4-Lite write channels.
  input  wire logic                                       s_axi_awvalid,
  output logic                                            s_axi_awready,
  input  wire logic [31:0]                                s_axi_awaddr,
  input  wire logic                                       s_axi_wvalid,
  output logic                                            s_axi_wready,
  input  wire logic [31:0]                                s_axi_wdata,
  input  wire logic [3:0]                                 s_axi_wstrb,
  output logic                                            s_axi_bvalid,
  input  wire logic                                       s_axi_bready,
  output logic [1:0]                                      s_axi_bresp,
  // AXI4-Lite read channels.
  input  wire logic                                       s_axi_arvalid,
  output logic                                            s_axi_arready,
  input  wire logic [31:0]                                s_axi_araddr,
  output logic                                            s_axi_rvalid,
  input  wire logic                                       s_axi_rready,
  output logic [31:0]                                     s_axi_rdata,
  output logic [1:0]                                      s_axi_rresp
);

  // Control register; bit 0 lets the decoder execute the group.
  logic [31:0] ctrl;
  // Latched write address and data, held until both are present.
  logic        aw_held;
  logic [31:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // One decoded strobe per opcode; decoding is gated by the enable bit.
  // Every compare spans all ten bits, so a neighbouring transfer opcode of
  // another peripheral can never alias into this group.
  wire decode_en = ctrl[`CTRL_DECODE_EN_BIT] & instr_valid;
  wire hit_pu2   = decode_en && instr_word == `OP_LOAD_PULLUP_CTRL_PORT2;
  wire hit_pu3   = decode_en && instr_word == `OP_LOAD_PULLUP_CTRL_PORT3;
  wire hit_rld   = decode_en && instr_word == `OP_LOAD_TIMER_ONE_RELOAD;
  wire hit_clk   = decode_en && instr_word == `OP_LOAD_CLOCK_CTRL;
  wire hit_ic1   = decode_en && instr_word == `OP_LOAD_INTERRUPT_CTRL_FIRST;
  wire hit_ic2   = decode_en && instr_word == `OP_LOAD_INTERRUPT_CTRL_SECOND;
  wire hit_tc1   = decode_en && instr_word == `OP_LOAD_TIMER_CTRL_FIRST;
  wire hit_tc2   = decode_en && instr_word == `OP_LOAD_TIMER_CTRL_SECOND;
  wire any_hit   = hit_pu2 | hit_pu3 | hit_rld | hit_clk | hit_ic1 | hit_ic2 | hit_tc1 | hit_tc2;

  // Every transfer of the group is single-cycle: no skip and no carry write.
  // The core keeps its own carry and skip logic; these constants tell it to
  // leave both alone for the whole group.
  assign effect.hit         = any_hit;
  assign effect.skip_next   = 1'b0;
  assign effect.carry_write = 1'b0;

  // Reset clears the whole bank at once, so no peripheral starts up with a
  // half-written setting.
  // Each register loads at the edge ending its instruction's cycle, so the
  // next instruction already sees the new setting.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph <= '0;
    end else begin
      if (hit_pu2) periph.pullup_ctrl_port_two   <= acc;
      if (hit_pu3) periph.pullup_ctrl_port_three <= acc;
      if (hit_rld) periph.timer_one_reload_value <= {reg_b, acc};
      if (hit_clk) periph.clock_source_control   <= acc[2:0];
      if (hit_ic1) periph.interrupt_ctrl_first   <= acc;
      if (hit_ic2) periph.interrupt_ctrl_second  <= acc;
      if (hit_tc1) periph.timer_ctrl_first       <= acc;
      if (hit_tc2) periph.timer_ctrl_second      <= acc;
    end
  end

  // Write path: address and data may come in either order.
  // Only one write is in flight: a second address or word waits until the
  // response is raised, which keeps the logic small at the cost of throughput.
  wire aw_take    = s_axi_awvalid & s_axi_awready;
  wire w_take     = s_axi_wvalid & s_axi_wready;
  wire wr_go      = aw_held & w_held & ~s_axi_bvalid;
  wire wr_to_ctrl = aw_addr[3:0] == `REG_CTRL_OFFSET && aw_addr[31:4] == 28'h000_0000;
  wire wr_mapped  = wr_to_ctrl
                 || (aw_addr[31:4] == 28'h000_0000 && aw_addr[3:0] == `REG_SHADOW_OFFSET)
                 || (aw_addr[31:4] == 28'h000_0000 && aw_addr[3:0] == `REG_RELOAD_OFFSET);
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;

  // Holding registers for the write channels.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Commit and response; only the control word is writable, the two
  // shadow words are read-only and accept a write without effect.
  // A write whose byte 0 strobe is clear leaves the enable bit untouched.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl         <= `CTRL_RESET_VALUE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        if (wr_to_ctrl && w_strb[0]) begin
          ctrl <= {31'h0000_0000, w_data[`CTRL_DECODE_EN_BIT]};
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: the shadow words show the block's live register state.
  wire        rd_hi_zero = s_axi_araddr[31:4] == 28'h000_0000;
  wire        rd_ctrl    = rd_hi_zero && s_axi_araddr[3:0] == `REG_CTRL_OFFSET;
  wire        rd_shadow  = rd_hi_zero && s_axi_araddr[3:0] == `REG_SHADOW_OFFSET;
  wire        rd_reload  = rd_hi_zero && s_axi_araddr[3:0] == `REG_RELOAD_OFFSET;
  wire [31:0] shadow_word = {5'h00, periph.timer_ctrl_second, periph.timer_ctrl_first,
                             periph.interrupt_ctrl_second, periph.interrupt_ctrl_first,
                             periph.clock_source_control, periph.pullup_ctrl_port_three,
                             periph.pullup_ctrl_port_two};
  wire [31:0] rd_word    = rd_ctrl   ? ctrl :
                           rd_shadow ? shadow_word :
                           rd_reload ? {24'h00_0000, periph.timer_one_reload_value} : 32'h0000_0000;
  assign s_axi_arready = ~s_axi_rvalid;

  // Read data register; one cycle from address to data.
  // An unmapped address answers with zero data and a slave error, so software
  // never mistakes a stale word for live state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_ctrl | rd_shadow | rd_reload) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks that tie each register to the opcode that loads it.
  a_pu2_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_pu2 |=> periph.pullup_ctrl_port_two == $past(acc)) else $error("Port 2 pull-up load wrong.");
  a_pu3_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_pu3 |=> periph.pullup_ctrl_port_three == $past(acc)) else $error("Port 3 pull-up load wrong.");
  a_reload_nibbles: assert property (@(posedge clk_sys) disable iff (rst)
    hit_rld |=> periph.timer_one_reload_value[7:4] == $past(reg_b)
             && periph.timer_one_reload_value[3:0] == $past(acc)) else $error("Reload nibble order wrong.");
  a_clock_low_bits: assert property (@(posedge clk_sys) disable iff (rst)
    hit_clk |=> periph.clock_source_control == $past(acc[2:0])) else $error("Clock control load wrong.");
  a_ic1_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_ic1 |=> periph.interrupt_ctrl_first == $past(acc) && !effect.skip_next) else $error("Int ctrl 1 wrong.");
  a_ic2_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_ic2 |=> periph.interrupt_ctrl_second == $past(acc)) else $error("Int ctrl 2 load wrong.");
  a_tc1_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_tc1 |=> periph.timer_ctrl_first == $past(acc)) else $error("Timer ctrl 1 load wrong.");
  a_tc2_load: assert property (@(posedge clk_sys) disable iff (rst)
    hit_tc2 |=> periph.timer_ctrl_second == $past(acc)) else $error("Timer ctrl 2 load wrong.");
  a_idle_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !any_hit |=> $stable(periph)) else $error("Control bank changed without a transfer.");
  a_no_side_effect: assert property (@(posedge clk_sys) disable iff (rst)
    any_hit |-> !effect.skip_next && !effect.carry_write) else $error("Transfer skipped or wrote carry.");

  // With the decoder switched off no opcode may claim the group.
  a_gate_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl[`CTRL_DECODE_EN_BIT] |-> !effect.hit) else $error("Hit while decoding is off.");
  // A cycle without a fetched word never executes anything.
  a_invalid_no_hit: assert property (@(posedge clk_sys) disable iff (rst)
    !instr_valid |-> !effect.hit) else $error("Hit without a valid word.");
  // Once address and data are both held, the response follows on the next edge.
  a_write_answer: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go |=> s_axi_bvalid) else $error("Write response missing.");
  // A write to the control word with byte 0 enabled stores the enable bit.
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && wr_to_ctrl && w_strb[0] |=> ctrl[`CTRL_DECODE_EN_BIT] == $past(w_data[`CTRL_DECODE_EN_BIT]))
    else $error("Enable bit not stored.");
  // A write to the control word with byte 0 masked leaves it alone.
  a_strobe_guard: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && wr_to_ctrl && !w_strb[0] |=> $stable(ctrl)) else $error("Masked write changed control.");
  // An accepted read address gives read data on the next edge.
  a_read_answer: assert property (@(posedge clk_sys) disable iff (rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("Read data missing.");
  // An unmapped read answers a slave error with zero data.
  a_read_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    s_axi_arvalid && s_axi_arready && !(rd_ctrl | rd_shadow | rd_reload)
    |=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("Unmapped read answered.");

endmodule

// ==== tb/instr_fetch_model.sv ====
// Purpose: Program fetch side that feeds the decoder one word per cycle.
// Assumes: The bench calls issue or idle once per clock.
// Notes:   Idle cycles show inverted fields, so stale words never look valid.
module instr_fetch_model (
  // Clock.
  input  wire logic       clk_sys,
  // Instruction stream.
  output logic            instr_valid,
  output logic [9:0]      instr_word,
  output logic [3:0]      acc,
  output logic [3:0]      reg_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Nothing is fetched at time zero.
  initial begin
    instr_valid = 1'b0;
    instr_word  = 10'h000;
    acc         = 4'h0;
    reg_b       = 4'h0;
  end

  // Presents one word with its operands for one cycle.
  task automatic issue(input logic [9:0] w, input logic [3:0] a, input logic [3:0] b);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word  <= w;
    acc         <= a;
    reg_b       <= b;
  endtask

  // A slow fetch: no word, and the fields are scrambled.
  task automatic idle();
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    instr_word  <= ~instr_word;
    acc         <= ~acc;
    reg_b       <= ~reg_b;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the accumulator transfer decoder.
// Assumes: The register port answers well inside the cycle ceiling.
// Notes:   Table rows run back to back, so each load is seen by the next word.
`include "accumulator_transfer_decode_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef accumulator_transfer_decode_pkg::periph_ctrl_t pc_t;
  logic        clk_sys, iv, awr, wr, bv, arr, rv;
  logic        rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [9:0]  iw;
  logic [3:0]  acc, rb;
  logic [3:0]  ws = 4'hF;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] awa = 32'h0000_0000, wd = 32'h0000_0000, ara = 32'h0000_0000, rd, got;
  accumulator_transfer_decode_pkg::exec_effect_t eff;
  pc_t         per, exp_p;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  // Ordinary cases: opcode, accumulator, register B.
  logic [17:0] rows [11] = '{{`OP_LOAD_PULLUP_CTRL_PORT2, 8'h50}, {`OP_LOAD_PULLUP_CTRL_PORT2, 8'hA0},
    {`OP_LOAD_PULLUP_CTRL_PORT3, 8'h6F}, {`OP_LOAD_TIMER_ONE_RELOAD, 8'hC3}, {`OP_LOAD_CLOCK_CTRL, 8'hF0},
    {`OP_LOAD_CLOCK_CTRL, 8'h20}, {`OP_LOAD_INTERRUPT_CTRL_FIRST, 8'h91}, {`OP_LOAD_INTERRUPT_CTRL_SECOND, 8'hE2},
    {`OP_LOAD_TIMER_CTRL_FIRST, 8'hB3}, {`OP_LOAD_TIMER_CTRL_SECOND, 8'hD4}, {10'h22E, 8'h75}};

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  instr_fetch_model fetch (.clk_sys(clk_sys), .instr_valid(iv), .instr_word(iw), .acc(acc), .reg_b(rb));
  accumulator_transfer_decode dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(iv), .instr_word(iw), .acc(acc),
    .reg_b(rb), .effect(eff), .periph(per), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compares words and single flags.
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // Compares the whole control bank.
  task automatic chk_per(input pc_t e);
    tests_run++;
    if (per !== e) begin
      n_errors++;
      $display("unexpected at %0t: control bank", $time);
    end
  endtask

  // Expected bank after one word; h tells whether the word belongs to the group while en is set.
  function automatic pc_t upd(input pc_t p, input logic [17:0] r, input logic en, output logic h);
    h = en;
    upd = p;
    if (en) case (r[17:8])
      `OP_LOAD_PULLUP_CTRL_PORT2:     upd.pullup_ctrl_port_two = r[7:4];
      `OP_LOAD_PULLUP_CTRL_PORT3:     upd.pullup_ctrl_port_three = r[7:4];
      `OP_LOAD_TIMER_ONE_RELOAD:      upd.timer_one_reload_value = {r[3:0], r[7:4]};
      `OP_LOAD_CLOCK_CTRL:            upd.clock_source_control = r[6:4];
      `OP_LOAD_INTERRUPT_CTRL_FIRST:  upd.interrupt_ctrl_first = r[7:4];
      `OP_LOAD_INTERRUPT_CTRL_SECOND: upd.interrupt_ctrl_second = r[7:4];
      `OP_LOAD_TIMER_CTRL_FIRST:      upd.timer_ctrl_first = r[7:4];
      `OP_LOAD_TIMER_CTRL_SECOND:     upd.timer_ctrl_second = r[7:4];
      default:                        h = 1'b0;
    endcase
  endfunction

  // Executes one word; the bank must already show the word before it.
  task automatic run(input logic [17:0] r, input logic en);
    logic h;
    fetch.issue(r[17:8], r[7:4], r[3:0]);
    @(negedge clk_sys);
    chk_per(exp_p);
    exp_p = upd(exp_p, r, en, h);
    chk_word({31'h0, eff.hit}, {31'h0, h}, "hit");
    chk_word({30'h0, eff.skip_next, eff.carry_write}, 32'h0, "skip or carry");
  endtask

  // Register write; address and data are held until both are taken.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    br  <= 1'b1;
    do @(negedge clk_sys); while ((awr & wr) !== 1'b1);
    @(posedge clk_sys);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(negedge clk_sys); while (bv !== 1'b1);
    rsp = bresp;
    @(posedge clk_sys);
    br <= 1'b0;
  endtask

  // Register read; data and response are taken with rvalid.
  task automatic axi_rd(input logic [31:0] a);
    @(posedge clk_sys);
    arv <= 1'b1;
    ara <= a;
    rr  <= 1'b1;
    do @(negedge clk_sys); while (arr !== 1'b1);
    @(posedge clk_sys);
    arv <= 1'b0;
    do @(negedge clk_sys); while (rv !== 1'b1);
    got = rd;
    rsp = rresp;
    @(posedge clk_sys);
    rr <= 1'b0;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  // Main sequence: enable read after reset, then table, disable, register faults and a second reset.
  initial begin
    exp_p = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk_per(exp_p);
    axi_rd(32'h0000_0000);
    chk_word(got, 32'h0000_0001, "enable after reset");
    chk_word({30'h0, rsp}, {30'h0, `AXI_RESP_OKAY}, "read response");
    foreach (rows[i]) run(rows[i], 1'b1);
    fetch.idle();
    @(negedge clk_sys);
    chk_per(exp_p);
    axi_rd(32'h0000_0004);
    chk_word(got, {5'h0, exp_p.timer_ctrl_second, exp_p.timer_ctrl_first, exp_p.interrupt_ctrl_second,
      exp_p.interrupt_ctrl_first, exp_p.clock_source_control, exp_p.pullup_ctrl_port_three,
      exp_p.pullup_ctrl_port_two}, "shadow");
    axi_rd(32'h0000_0008);
    chk_word(got, {24'h0, exp_p.timer_one_reload_value}, "reload view");
    axi_wr(32'h0000_0000, 32'h0000_0000);
    chk_word({30'h0, rsp}, {30'h0, `AXI_RESP_OKAY}, "write response");
    run({`OP_LOAD_TIMER_CTRL_FIRST, 8'h10}, 1'b0);
    fetch.idle();
    axi_wr(32'h0000_0000, 32'h0000_0001);
    run({`OP_LOAD_TIMER_CTRL_FIRST, 8'h60}, 1'b1);
    fetch.idle();
    @(negedge clk_sys);
    chk_per(exp_p);
    axi_wr(32'h0000_000C, 32'h0000_0001);
    chk_word({30'h0, rsp}, {30'h0, `AXI_RESP_SLVERR}, "unmapped write");
    axi_rd(32'h0000_0010);
    chk_word({30'h0, rsp}, {30'h0, `AXI_RESP_SLVERR}, "unmapped read");
    chk_word(got, 32'h0000_0000, "unmapped read data");
    ws <= 4'hE;
    axi_wr(32'h0000_0000, 32'h0000_0000);
    axi_rd(32'h0000_0000);
    chk_word(got, 32'h0000_0001, "masked enable write");
    ws <= 4'hF;
    axi_wr(32'h0000_0000, 32'h0000_0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk_per('0);
    chk_word({27'h0, awr, wr, arr, bv, rv}, 32'h0000_001C, "bus idle after reset");
    axi_rd(32'h0000_0000);
    chk_word(got, 32'h0000_0001, "enable after second reset");
    print_verdict();
  end
endmodule
